//--- logic/gdb_top.sv
// global data bus configuration and allocation block
//
// Functional notes
// - bus address is 0 to 31; at most 32 stations.
// - configured address sets the token turn of this station.
// - addresses 16 to 23 map to consecutive 32-bit memory windows.
// - maximum length is memory left from window start to bit 256.
// - reset gives 32-bit send length and no receive lengths.
// - slots covered by a long sender must not be used by senders.
// - view hides slots covered by own send length over 32 bits.
// - separate receive length per address 16-23; zero means none.
// - one line rate of four settings for all stations.
// - reset selects 153.6 standard rate.
// - at 38.4 rate the bus carries at most 16 stations; the control write does not check this limit and tests the address only against the send length.
// - configured and stopped: run the bus, send zeros.
// - on run, hold configuration and send real data.
// - host data held until token arrives, then broadcast.
// - own message sent once per bus scan.
// - message framed by open byte and close byte.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module gdb_top #(
    parameter int ADDR_BITS = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic token_pin,
    input wire logic rx_valid_pin,
    input wire logic [4:0] rx_src_pin,
    input wire logic [7:0] rx_byte_pin,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic [4:0] bus_addr,
    output gdb_pkg::gdb_rate_t line_rate,
    output logic bus_active,
    output logic cfg_err
);
    import gdb_pkg::*;
    // control: bit0 configured, bit1 run, [6:2] addr, [8:7] rate
    logic cfg_q, cfg_d, run_q, run_d, err_q, err_d;
    logic [4:0] addr_q, addr_d;
    gdb_rate_t rate_q, rate_d;
    logic [8:0] tx_len_q, tx_len_d;
    logic [8:0] rx_len_q [NUM_WIN];
    logic [8:0] rx_len_d [NUM_WIN];
    logic [31:0] mem_q [MEM_WORDS];
    logic [31:0] mem_d [MEM_WORDS];
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    gdb_tx_state_t st_q, st_d;
    logic [5:0] bcnt_q, bcnt_d;
    logic [7:0] txb_q, txb_d;
    logic txv_q, txv_d;
    logic [4:0] s1_q, s2_q;
    logic [2:0] pin1_q, pin2_q, pin3_q;
    logic [7:0] rb1_q, rb2_q;
    logic [4:0] rsrc_q, rsrc_d;
    logic [5:0] rcnt_q, rcnt_d;
    logic acc, wr, rd;
    logic [2:0] widx;
    logic [7:0] view;
    logic ck_ok, ck_ok_tx;
    logic tok_rise, rx_v;
    logic [4:0] rx_src;
    logic [2:0] ridx;
    logic [7:0] rx_b;
    logic [7:0] cur_byte;
    logic [7:0] mem_byte;
    logic [2:0] roff;
    logic [5:0] bnext, rk;
    logic [8:0] rlen;
    gdb_cfg_if ci();
    gdb_cfg_if ct();
    gdb_len_check u_chk (
        .c(ci)
    );
    gdb_len_check u_chk_tx (
        .c(ct)
    );
    gdb_view #(
        .N(NUM_WIN)
    ) u_view (
        .v(ct)
    );
    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign widx = paddr[4:2];
    assign ci.addr = 5'(WIN_FIRST + {2'h0, widx});
    assign ci.len = pwdata[8:0];
    assign ck_ok = ci.ok;
    assign ct.addr = (paddr == OFS_CTRL) ? pwdata[6:2] : addr_q;
    assign ct.len = (paddr == OFS_TXLEN) ? pwdata[8:0] : tx_len_q;
    assign ct.tx_len = tx_len_q;
    assign ck_ok_tx = ct.ok;
    assign view = ct.view;
    assign tok_rise = pin2_q[0] && !pin3_q[0];
    assign rx_v = pin2_q[1] && !pin3_q[1];
    assign rx_src = s2_q;
    assign rx_b = rb2_q;
    assign ridx = 3'(rx_src - WIN_FIRST);
    assign rk = 6'(rcnt_q - 6'h01);
    assign rlen = ((rx_src >= WIN_FIRST) && (rx_src <= WIN_LAST)) ?
                  rx_len_q[ridx] : RX_LEN_RST;
    // pin inputs pass two flops before any logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin1_q <= 3'h0;
            pin2_q <= 3'h0;
            pin3_q <= 3'h0;
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            rb1_q <= 8'h00;
            rb2_q <= 8'h00;
        end else begin
            pin1_q <= {1'b0, rx_valid_pin, token_pin};
            pin2_q <= pin1_q;
            pin3_q <= pin2_q;
            s1_q <= rx_src_pin;
            s2_q <= s1_q;
            rb1_q <= rx_byte_pin;
            rb2_q <= rb1_q;
        end
    end
    always_comb begin
        bnext = (st_q == GDB_DATA) ? 6'(bcnt_q + 6'h01) : 6'h00;
        roff = 3'(addr_q - WIN_FIRST) + 3'(bnext[5:2]);
        mem_byte = mem_q[roff][8'(bnext[1:0]) * 8 +: 8];
        cur_byte = run_q ? mem_byte : 8'h00;
    end
    // register file, receive path and message sender
    always_comb begin
        cfg_d = cfg_q;
        run_d = run_q;
        addr_d = addr_q;
        rate_d = rate_q;
        err_d = err_q;
        tx_len_d = tx_len_q;
        rx_len_d = rx_len_q;
        mem_d = mem_q;
        prdata_d = prdata_q;
        pready_d = psel && !penable;
        pslverr_d = 1'b0;
        st_d = st_q;
        bcnt_d = bcnt_q;
        txb_d = txb_q;
        txv_d = txv_q;
        rsrc_d = rsrc_q;
        rcnt_d = rcnt_q;
        if (rd) begin
            prdata_d = 32'h0000_0000;
            if (paddr == OFS_CTRL) begin
                prdata_d = {23'h0, rate_q, addr_q, run_q, cfg_q};
            end else if (paddr == OFS_STATUS) begin
                prdata_d = {30'h0, st_q != GDB_IDLE, err_q};
            end else if (paddr == OFS_TXLEN) begin
                prdata_d = {23'h0, tx_len_q};
            end else if (paddr == OFS_VIEW) begin
                prdata_d = {24'h0, view};
            end else if (paddr[11:5] == OFS_RXLEN0[11:5]) begin
                prdata_d = {23'h0, rx_len_q[widx]};
            end else if (paddr[11:5] == OFS_MEM0[11:5]) begin
                prdata_d = mem_q[widx];
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == OFS_CTRL) begin
                run_d = pwdata[1];
                // configuration held while running
                if (!run_q) begin
                    if (ck_ok_tx) begin
                        cfg_d = pwdata[0];
                        addr_d = pwdata[6:2];
                        rate_d = gdb_rate_t'(pwdata[8:7]);
                    end else begin
                        err_d = 1'b1;
                    end
                end
            end else if (paddr == OFS_STATUS) begin
                err_d = err_q && !pwdata[0];
            end else if (paddr == OFS_TXLEN && !run_q) begin
                if (ck_ok_tx) begin
                    tx_len_d = pwdata[8:0];
                end else begin
                    err_d = 1'b1;
                end
            end else if (paddr[11:5] == OFS_RXLEN0[11:5] && !run_q) begin
                if (ck_ok) begin
                    rx_len_d[widx] = pwdata[8:0];
                end else begin
                    err_d = 1'b1;
                end
            end else if (paddr[11:5] == OFS_MEM0[11:5]) begin
                mem_d[widx] = pwdata;
            end
        end
        // receive: open byte starts a frame, data fill the sender's window
        if (rx_v) begin
            if (rcnt_q == 6'h00 || rsrc_q != rx_src) begin
                rsrc_d = rx_src;
                rcnt_d = (rx_b == BLOCK_OPEN_BYTE) ? 6'h01 : 6'h00;
            end else if ({rk, 3'h0} < rlen) begin
                if (run_q) begin
                    mem_d[3'(ridx + 3'(rk[5:2]))][8'(rk[1:0]) * 8 +: 8]
                        = rx_b;
                end
                rcnt_d = 6'(rcnt_q + 6'h01);
            end else if (rx_b == BLOCK_CLOSE_BYTE) begin
                rcnt_d = 6'h00;
            end
        end
        // sender: once per token visit
        case (st_q)
            GDB_IDLE: begin
                if (tok_rise && cfg_q) begin
                    st_d = GDB_OPEN;
                end
            end
            GDB_OPEN: begin
                txb_d = BLOCK_OPEN_BYTE;
                txv_d = 1'b1;
                bcnt_d = 6'h00;
                if (txv_q && tx_ready) begin
                    st_d = GDB_DATA;
                    txb_d = cur_byte;
                end
            end
            GDB_DATA: begin
                if (tx_ready) begin
                    bcnt_d = 6'(bcnt_q + 6'h01);
                    if ({bcnt_q + 6'h01, 3'h0} >= tx_len_q) begin
                        st_d = GDB_CLOSE;
                        txb_d = BLOCK_CLOSE_BYTE;
                    end else begin
                        txb_d = cur_byte;
                    end
                end
            end
            GDB_CLOSE: begin
                if (tx_ready) begin
                    txv_d = 1'b0;
                    st_d = GDB_DONE;
                end
            end
            GDB_DONE: begin
                if (!pin2_q[0]) begin
                    st_d = GDB_IDLE;
                end
            end
            default: begin
                st_d = GDB_IDLE;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 1'b0;
            run_q <= 1'b0;
            err_q <= 1'b0;
            addr_q <= ADDR_RST;
            rate_q <= GDB_RATE_STD;
            tx_len_q <= TX_LEN_RST;
            for (int i = 0; i < NUM_WIN; i++) begin
                rx_len_q[i] <= RX_LEN_RST;
            end
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem_q[i] <= 32'h0000_0000;
            end
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            st_q <= GDB_IDLE;
            bcnt_q <= 6'h00;
            txb_q <= 8'h00;
            txv_q <= 1'b0;
            rsrc_q <= 5'h00;
            rcnt_q <= 6'h00;
        end else begin
            cfg_q <= cfg_d;
            run_q <= run_d;
            err_q <= err_d;
            addr_q <= addr_d;
            rate_q <= rate_d;
            tx_len_q <= tx_len_d;
            rx_len_q <= rx_len_d;
            mem_q <= mem_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            st_q <= st_d;
            bcnt_q <= bcnt_d;
            txb_q <= txb_d;
            txv_q <= txv_d;
            rsrc_q <= rsrc_d;
            rcnt_q <= rcnt_d;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_byte = txb_q;
    assign tx_valid = txv_q;
    assign bus_addr = addr_q;
    assign line_rate = rate_q;
    assign bus_active = cfg_q;
    assign cfg_err = err_q;
endmodule // gdb_top
`default_nettype wire

//--- logic/gdb_pkg.sv
// package for the global data bus configuration block
package gdb_pkg;
    localparam int ADDR_W = 5;
    localparam int NUM_STATIONS = 32;
    localparam logic [4:0] WIN_FIRST = 5'h10;
    localparam logic [4:0] WIN_LAST = 5'h17;
    localparam int NUM_WIN = 8;
    localparam int WIN_BITS = 32;
    localparam int MEM_BITS = 256;
    localparam int MEM_WORDS = 8;
    localparam int LEN_W = 9;
    localparam logic [8:0] LEN_UNIT = 9'h020;
    localparam logic [8:0] LEN_MAX = 9'h100;
    localparam logic [8:0] TX_LEN_RST = 9'h020;
    localparam logic [8:0] RX_LEN_RST = 9'h000;
    localparam logic [4:0] ADDR_RST = 5'h10;
    localparam int MAX_AT_LOW_RATE = 16;
    localparam logic [7:0] BLOCK_OPEN_BYTE = 8'hA5;
    localparam logic [7:0] BLOCK_CLOSE_BYTE = 8'h5A;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TXLEN = 12'h008;
    localparam logic [11:0] OFS_RXLEN0 = 12'h020;
    localparam logic [11:0] OFS_MEM0 = 12'h040;
    localparam logic [11:0] OFS_VIEW = 12'h00C;
    typedef enum logic [1:0] {
        GDB_RATE_STD = 2'b00,
        GDB_RATE_EXT = 2'b01,
        GDB_RATE_768 = 2'b10,
        GDB_RATE_384 = 2'b11
    } gdb_rate_t;
    typedef enum logic [2:0] {
        GDB_IDLE = 3'b000,
        GDB_OPEN = 3'b001,
        GDB_DATA = 3'b010,
        GDB_CLOSE = 3'b011,
        GDB_DONE = 3'b100
    } gdb_tx_state_t;
endpackage

//--- logic/gdb_cfg_if.sv
// configuration carrier between the top and its helpers
`timescale 1ns/100ps
`default_nettype none
interface gdb_cfg_if;
    import gdb_pkg::*;
    logic [4:0] addr;
    logic [8:0] len;
    logic ok;
    logic [7:0] view;
    logic [8:0] tx_len;
    modport chk(input addr, input len, output ok);
    modport top(output addr, output len, input ok);
    modport vw(input addr, input tx_len, output view);
    modport topv(output tx_len, input view);
endinterface
`default_nettype wire

//--- logic/gdb_len_check.sv
// length legality check for one address
`timescale 1ns/100ps
`default_nettype none
module gdb_len_check (
    gdb_cfg_if.chk c
);
    import gdb_pkg::*;
    logic [8:0] room;
    logic in_win;
    always_comb begin
        in_win = (c.addr >= WIN_FIRST) && (c.addr <= WIN_LAST);
        // room from window start up to the top of memory
        room = LEN_MAX - 9'(({4'h0, c.addr} - {4'h0, WIN_FIRST}) * LEN_UNIT);
        c.ok = (c.len[4:0] == 5'h00) &&
               (in_win ? (c.len <= room) : (c.len == 9'h000));
    end
endmodule // gdb_len_check
`default_nettype wire

//--- logic/gdb_view.sv
// slot availability view from own send length
`timescale 1ns/100ps
`default_nettype none
module gdb_view #(
    parameter int N = 8
) (
    gdb_cfg_if.vw v
);
    import gdb_pkg::*;
    logic [3:0] own;
    logic [3:0] span;
    always_comb begin
        own = 4'(v.addr - WIN_FIRST);
        span = 4'(v.tx_len[8:5]);
    end
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_slot
            // slot shown unless covered by own long message
            assign v.view[g] = !((v.addr >= WIN_FIRST) &&
                (v.addr <= WIN_LAST) && (4'(g) > own) &&
                (4'(g) < 4'(own + span)));
        end
    endgenerate
endmodule // gdb_view
`default_nettype wire

//--- dv/gdb_top_sva.sv
// port checker of the global data bus block
`timescale 1ns/100ps
`default_nettype none
module gdb_top_sva
    import gdb_pkg::*;
#(
    parameter int ADDR_BITS = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic token_pin,
    input wire logic rx_valid_pin,
    input wire logic [4:0] rx_src_pin,
    input wire logic [7:0] rx_byte_pin,
    input wire logic tx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic [4:0] bus_addr,
    input wire gdb_pkg::gdb_rate_t line_rate,
    input wire logic bus_active,
    input wire logic cfg_err
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_token_new;
        $rose(token_pin) && bus_active && !tx_valid;
    endsequence
    property p_answer;
        s_setup |=> pready && psel && penable;
    endproperty
    property p_slverr;
        pslverr |-> pready && !pwrite;
    endproperty
    property p_rate_cause;
        !$stable(line_rate) |-> $past(psel) && $past(penable) && $past(pwrite);
    endproperty
    property p_addr_cause;
        !$stable(bus_addr) |-> $past(psel) && $past(penable) && $past(pwrite);
    endproperty
    property p_err_cause;
        $rose(cfg_err) |-> $past(psel) && $past(penable) && $past(pwrite);
    endproperty
    property p_open;
        $rose(tx_valid) |-> tx_byte == BLOCK_OPEN_BYTE;
    endproperty
    property p_close;
        $fell(tx_valid) |-> $past(tx_byte) == BLOCK_CLOSE_BYTE;
    endproperty
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
    endproperty
    property p_token;
        s_token_new |-> ##[1:12] tx_valid;
    endproperty
    property p_reset;
        $rose(presetn) |-> bus_addr == ADDR_RST && line_rate == GDB_RATE_STD;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no zero wait answer");
    a_slverr: assert property (p_slverr)
        else $error("stray slave error");
    a_rate_cause: assert property (p_rate_cause)
        else $error("rate changed without write");
    a_addr_cause: assert property (p_addr_cause)
        else $error("address changed without write");
    a_err_cause: assert property (p_err_cause)
        else $error("error flag without write");
    a_open: assert property (p_open)
        else $error("message not opened");
    a_close: assert property (p_close)
        else $error("message not closed");
    a_hold: assert property (p_hold)
        else $error("byte dropped while stalled");
    a_token: assert property (p_token)
        else $error("no message on token");
    a_reset: assert property (p_reset)
        else $error("bad reset setup");
endmodule // gdb_top_sva
bind gdb_top gdb_top_sva #(.ADDR_BITS(ADDR_BITS)) gdb_top_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .token_pin(token_pin),
    .rx_valid_pin(rx_valid_pin), .rx_src_pin(rx_src_pin),
    .rx_byte_pin(rx_byte_pin), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .bus_addr(bus_addr), .line_rate(line_rate),
    .bus_active(bus_active), .cfg_err(cfg_err)
);
`default_nettype wire

//--- dv/gdb_peer.sv
// peer station model on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module gdb_peer
    import gdb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic token_pin,
    output logic rx_valid_pin,
    output logic [4:0] rx_src_pin,
    output logic [7:0] rx_byte_pin
);
    logic [7:0] got [$];
    initial begin
        tx_ready = 0;
        token_pin = 0;
        rx_valid_pin = 0;
        rx_src_pin = 5'h00;
        rx_byte_pin = 8'h00;
    end
    // link accepts bytes with random stalls
    always @(posedge pclk) begin
        tx_ready <= presetn && ($urandom % 3 != 0);
        if (tx_valid && tx_ready)
            got.push_back(tx_byte);
    end
    // token held until the message is in, then a quiet gap
    task automatic pass_token(input int nb);
        got.delete();
        @(posedge pclk);
        token_pin <= 1;
        for (int n = 0; n < 600 && got.size() < nb; n++)
            @(posedge pclk);
        token_pin <= 0;
        repeat (20) @(posedge pclk);
    endtask
    // one framed message, low byte first
    task automatic send_frame(input logic [4:0] src, input logic [31:0] w);
        logic [7:0] b [6];
        b = '{BLOCK_OPEN_BYTE, w[7:0], w[15:8], w[23:16], w[31:24],
              BLOCK_CLOSE_BYTE};
        foreach (b[i]) begin
            @(posedge pclk);
            rx_src_pin <= src;
            rx_byte_pin <= b[i];
            rx_valid_pin <= 1;
            repeat (3) @(posedge pclk);
            rx_valid_pin <= 0;
            repeat (3) @(posedge pclk);
        end
        rx_src_pin <= ~src;
        rx_byte_pin <= ~b[5];
    endtask
endmodule // gdb_peer
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench of the global data bus block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import gdb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, v0, v1;
    logic pready, pslverr, token_pin, rx_valid_pin, tx_ready, tx_valid;
    logic bus_active, cfg_err;
    logic [4:0] rx_src_pin, bus_addr;
    logic [7:0] rx_byte_pin, tx_byte;
    gdb_rate_t line_rate;
    int err_total = 0, comparisons = 0, mx;
    logic [31:0] mem [8];
    logic [7:0] q [$];
    always #20 pclk = ~pclk;
    gdb_top gdb_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .token_pin(token_pin),
        .rx_valid_pin(rx_valid_pin), .rx_src_pin(rx_src_pin),
        .rx_byte_pin(rx_byte_pin), .tx_ready(tx_ready), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .bus_addr(bus_addr), .line_rate(line_rate),
        .bus_active(bus_active), .cfg_err(cfg_err)
    );
    gdb_peer gdb_peer_inst (
        .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .token_pin(token_pin),
        .rx_valid_pin(rx_valid_pin), .rx_src_pin(rx_src_pin),
        .rx_byte_pin(rx_byte_pin)
    );
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            err_total++;
            $display("CHECK FAILED %0t: saw %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            chk(0, 1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, v1, e1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        apb(0, a, 0, v1, e1);
        chk(32'(e1), 32'(xe));
        if (!xe)
            chk(v1, x);
    endtask
    function automatic logic [31:0] ctl(int a, int rt, int run);
        return {23'h0, rt[1:0], a[4:0], run[0], 1'b1};
    endfunction
    // own message at address 20 compared byte by byte
    task automatic frame(input int n, input logic live);
        q = {BLOCK_OPEN_BYTE};
        for (int i = 0; i < n / 8; i++)
            q.push_back(live ? mem[4 + i / 4][8 * (i % 4) +: 8] : 8'h00);
        q.push_back(BLOCK_CLOSE_BYTE);
        gdb_peer_inst.pass_token(q.size());
        chk(32'(gdb_peer_inst.got.size()), 32'(q.size()));
        foreach (q[i])
            chk(32'(gdb_peer_inst.got[i]), 32'(q[i]));
    endtask
    initial begin
        mx = $urandom(1);
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        chk(32'(bus_addr), 32'(ADDR_RST));
        chk(32'(line_rate), 32'(GDB_RATE_STD));
        chk(32'(bus_active), 0);
        rd(OFS_TXLEN, 32'(TX_LEN_RST), 0);
        for (int i = 0; i < 8; i++)
            rd(OFS_RXLEN0 + 12'(4 * i), 0, 0);
        rd(12'hFFC, 0, 1);
        for (int a = 16; a < 24; a++) begin
            mx = 256 - 32 * (a - 16);
            wr(OFS_CTRL, ctl(a, a % 3, 0));
            chk(32'(bus_addr), 32'(a));
            chk(32'(bus_active), 1);
            chk(32'(line_rate), 32'(a % 3));
            wr(OFS_TXLEN, 32'(mx));
            rd(OFS_TXLEN, 32'(mx), 0);
            chk(32'(cfg_err), 0);
            for (int b = 0; b < 2; b++) begin
                wr(OFS_TXLEN, 32'(b ? mx + 32 : mx - 16));
                rd(OFS_TXLEN, 32'(mx), 0);
                chk(32'(cfg_err), 1);
                wr(OFS_STATUS, 1);
            end
            wr(OFS_TXLEN, 32'h20);
        end
        wr(OFS_CTRL, ctl(16, 3, 0));
        chk(32'(line_rate), 32'(GDB_RATE_384));
        wr(OFS_CTRL, ctl(20, 0, 0));
        apb(0, OFS_VIEW, 0, v0, e1);
        wr(OFS_TXLEN, 32'h40);
        apb(0, OFS_VIEW, 0, v1, e1);
        chk(v0, 32'h0000_00FF);
        chk(v1, 32'h0000_00DF);
        for (int i = 0; i < 8; i++) begin
            mem[i] = $urandom;
            wr(OFS_MEM0 + 12'(4 * i), mem[i]);
        end
        wr(OFS_RXLEN0 + 12'h008, 32'h20);
        wr(OFS_RXLEN0 + 12'h00C, 0);
        frame(64, 0);
        wr(OFS_CTRL, ctl(20, 0, 1));
        frame(64, 1);
        mem[5] = $urandom;
        wr(OFS_MEM0 + 12'h014, mem[5]);
        frame(64, 1);
        wr(OFS_TXLEN, 32'h20);
        rd(OFS_TXLEN, 32'h40, 0);
        for (int s = 18; s < 20; s++) begin
            v0 = $urandom;
            gdb_peer_inst.send_frame(5'(s), v0);
            if (s == 18)
                mem[2] = v0;
            rd(OFS_MEM0 + 12'(4 * (s - 16)), mem[s - 16], 0);
        end
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
